// ===== inc/cgc_map.svh
// Purpose: offsets, field positions and reset values of the clock generator id/detector map
// Assumes: 10-bit register address, 8-bit register data
// Notes:   definitions only
`ifndef CGC_MAP_SVH
`define CGC_MAP_SVH

// register addresses
`define CGC_ADDR_VARIANT   10'h003
`define CGC_ADDR_RB_SEL    10'h004
`define CGC_ADDR_TAG_LO    10'h005
`define CGC_ADDR_TAG_HI    10'h006
`define CGC_ADDR_PUMP_CTRL 10'h010

// storage slot indices of the writable registers
`define CGC_NUM_SLOTS      4
`define CGC_IDX_RB_SEL     2'h0
`define CGC_IDX_TAG_LO     2'h1
`define CGC_IDX_TAG_HI     2'h2
`define CGC_IDX_PUMP_CTRL  2'h3

// field positions
`define CGC_RB_SEL_BIT     0
`define CGC_SENSE_BIT      7
`define CGC_PUMP_MSB       6
`define CGC_PUMP_LSB       4

// masks and reset values
`define CGC_RB_SEL_MASK    8'h01
`define CGC_RST_RB_SEL     8'h00
`define CGC_RST_TAG        8'h00
`define CGC_RST_PUMP_CTRL  8'h7D
`define CGC_RST_RDATA      8'h00

`endif

// ===== inc/cgc_pkg.sv
// Purpose: types shared by the clock generator id/detector register block
// Assumes: cgc_map.svh supplies the slot count
// Notes:   types only
`include "cgc_map.svh"
package cgc_pkg;
   typedef logic [9:0] cgc_addr_t;
   typedef logic [7:0] cgc_byte_t;
   typedef logic [1:0] cgc_idx_t;
   typedef logic [2:0] cgc_pump_t;
   typedef logic [`CGC_NUM_SLOTS-1:0][7:0] cgc_slots_t;
   // which copy a readback returns
   typedef enum logic {
      CGC_BANK_BUFFER = 1'b0,
      CGC_BANK_ACTIVE = 1'b1
   } cgc_bank_t;
   // result of decoding an address onto a storage slot
   typedef struct packed {
      logic     hit;
      cgc_idx_t idx;
   } cgc_slot_hit_t;
endpackage

// ===== inc/cgc_bank_if.sv
// Purpose: carries writes and transfer strobe to the storage module, and both register copies back from it
// Assumes: one clock domain
// Notes:   ctrl side decodes, store side holds the flops
`timescale 1ns/100ps
`default_nettype none
interface cgc_bank_if;
   import cgc_pkg::*;
   logic       wrEn;
   cgc_idx_t   wrIdx;
   cgc_byte_t  wrData;
   logic       xfer;
   cgc_slots_t bufSlots;
   cgc_slots_t actSlots;
   modport store (input wrEn, input wrIdx, input wrData, input xfer,
                  output bufSlots, output actSlots);
   modport ctrl  (output wrEn, output wrIdx, output wrData, output xfer,
                  input bufSlots, input actSlots);
endinterface
`default_nettype wire

// ===== rtl/cgc_bank.sv
// Purpose: buffer and active copies of the writable registers
// Assumes: synchronous active-low reset, writes land in the buffer copy only
// Notes:   xfer copies the whole buffer into the active copy in one edge
`timescale 1ns/100ps
`default_nettype none
`include "cgc_map.svh"
module cgc_bank (
   input wire logic   sys_clk,
   input wire logic   reset_n,
   cgc_bank_if.store  bank
);
   import cgc_pkg::*;

   cgc_slots_t bufQ;
   cgc_slots_t bufD;
   cgc_slots_t actQ;
   cgc_slots_t actD;

   // power-on contents, shared by both copies
   function automatic cgc_slots_t slotResets();
      cgc_slots_t r;
      r = '0;
      r[`CGC_IDX_RB_SEL]    = `CGC_RST_RB_SEL;
      r[`CGC_IDX_TAG_LO]    = `CGC_RST_TAG;
      r[`CGC_IDX_TAG_HI]    = `CGC_RST_TAG;
      r[`CGC_IDX_PUMP_CTRL] = `CGC_RST_PUMP_CTRL;
      return r;
   endfunction

   // next state; a transfer in the same cycle as a write moves the old buffer value
   always_comb begin
      bufD = bufQ;
      actD = actQ;
      if (!reset_n) begin
         bufD = slotResets();
         actD = slotResets();
      end else begin
         if (bank.xfer) begin
            actD = bufQ;
         end
         if (bank.wrEn) begin
            bufD[bank.wrIdx] = bank.wrData;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      bufQ <= bufD;
      actQ <= actD;
   end

   assign bank.bufSlots = bufQ;
   assign bank.actSlots = actQ;
endmodule
`default_nettype wire

// ===== rtl/cgc_regs.sv
// Purpose: register back end of the serial control port for the id and detector registers
// Assumes: serial port front end delivers decoded single-cycle read and write strobes
// Behaviour
// - read-only variant identifier at 0x003
// - 0x004 bit 0 selects buffer or active readback
// - 16-bit version tag at 0x005 and 0x006
// - version tag resets zero, affects nothing
// - 0x010 bit 7 sets detector sense
// - 0x010 bits 6:4 select pump current
`timescale 1ns/100ps
`default_nettype none
`include "cgc_map.svh"
module cgc_regs #(
   parameter cgc_pkg::cgc_byte_t VARIANT_ID = 8'h5A // arbitrary value, set per variant
) (
   input  wire logic                sys_clk,
   input  wire logic                reset_n,
   input  wire cgc_pkg::cgc_addr_t  regAddr,
   input  wire cgc_pkg::cgc_byte_t  regWrData,
   input  wire logic                regWrEn,
   input  wire logic                regRdEn,
   input  wire logic                updateActive,
   output var  cgc_pkg::cgc_byte_t  regRdData,
   output logic                     regRdValid,
   output logic                     phaseDetectorSense,
   output var  cgc_pkg::cgc_pump_t  pumpCurrentSelect
);
   import cgc_pkg::*;

   cgc_bank_if    bankBus ();
   cgc_slot_hit_t slotHit;
   cgc_bank_t     rbBank;
   cgc_byte_t     rdValue;
   cgc_byte_t     rdDataQ;
   cgc_byte_t     rdDataD;
   logic          rdValidQ;
   logic          rdValidD;

   // map an address onto a storage slot; the identifier is not a slot
   function automatic cgc_slot_hit_t slotOf(cgc_addr_t a);
      cgc_slot_hit_t s;
      s = '0;
      unique case (a)
         `CGC_ADDR_RB_SEL:    s = '{hit: 1'b1, idx: `CGC_IDX_RB_SEL};
         `CGC_ADDR_TAG_LO:    s = '{hit: 1'b1, idx: `CGC_IDX_TAG_LO};
         `CGC_ADDR_TAG_HI:    s = '{hit: 1'b1, idx: `CGC_IDX_TAG_HI};
         `CGC_ADDR_PUMP_CTRL: s = '{hit: 1'b1, idx: `CGC_IDX_PUMP_CTRL};
         default:             s = '0;
      endcase
      return s;
   endfunction

   // only bit 0 of the readback select exists; the rest stores and reads as zero
   function automatic cgc_byte_t writeMask(cgc_idx_t i, cgc_byte_t d);
      return (i == `CGC_IDX_RB_SEL) ? (d & `CGC_RB_SEL_MASK) : d;
   endfunction

   cgc_bank u_bank (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .bank    (bankBus.store)
   );

   // write steering; a write to the identifier finds no slot and is dropped
   always_comb begin
      slotHit         = slotOf(regAddr);
      bankBus.wrEn    = regWrEn && slotHit.hit;
      bankBus.wrIdx   = slotHit.idx;
      bankBus.wrData  = writeMask(slotHit.idx, regWrData);
      bankBus.xfer    = updateActive;
   end

   // the select bit acts at once from the buffer copy so software can read active
   // values without first transferring
   always_comb begin
      rbBank = cgc_bank_t'(bankBus.bufSlots[`CGC_IDX_RB_SEL][`CGC_RB_SEL_BIT]);
   end

   // readback value; unmapped addresses return zero
   always_comb begin
      rdValue = `CGC_RST_RDATA;
      if (regAddr == `CGC_ADDR_VARIANT) begin
         rdValue = VARIANT_ID;
      end else if (slotHit.hit) begin
         rdValue = (rbBank == CGC_BANK_ACTIVE) ? bankBus.actSlots[slotHit.idx]
                                               : bankBus.bufSlots[slotHit.idx];
      end
   end

   // read data holds until the next read
   always_comb begin
      rdValidD = 1'b0;
      rdDataD  = rdDataQ;
      if (reset_n) begin
         rdValidD = regRdEn;
         if (regRdEn) begin
            rdDataD = rdValue;
         end
      end else begin
         rdDataD = `CGC_RST_RDATA;
      end
   end

   always_ff @(posedge sys_clk) begin
      rdDataQ  <= rdDataD;
      rdValidQ <= rdValidD;
   end

   assign regRdData  = rdDataQ;
   assign regRdValid = rdValidQ;

   // loop controls come from the active copy; the tag bytes feed nothing
   assign phaseDetectorSense = bankBus.actSlots[`CGC_IDX_PUMP_CTRL][`CGC_SENSE_BIT];
   assign pumpCurrentSelect  =
      bankBus.actSlots[`CGC_IDX_PUMP_CTRL][`CGC_PUMP_MSB:`CGC_PUMP_LSB];

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   property p_variant_read;
      regRdEn && regAddr == `CGC_ADDR_VARIANT |=> regRdValid && regRdData == VARIANT_ID;
   endproperty
   a_variant_read: assert property (p_variant_read) else $error("variant id misread");

   property p_variant_ro;
      regWrEn && regAddr == `CGC_ADDR_VARIANT |=> $stable(bankBus.bufSlots);
   endproperty
   a_variant_ro: assert property (p_variant_ro) else $error("id write altered state");

   property p_bank_sel;
      regRdEn && slotHit.hit && rbBank == CGC_BANK_ACTIVE
      |=> regRdData == $past(bankBus.actSlots[slotHit.idx]);
   endproperty
   a_bank_sel: assert property (p_bank_sel) else $error("active readback wrong");

   // a tag byte comes back from the buffer; exactly one idle cycle sits between write and read
   property p_tag_store;
      regWrEn && regAddr == `CGC_ADDR_TAG_HI ##1 !regWrEn ##1
      regRdEn && !regWrEn && regAddr == `CGC_ADDR_TAG_HI && rbBank == CGC_BANK_BUFFER
      |=> regRdData == $past(regWrData, 3);
   endproperty
   a_tag_store: assert property (p_tag_store) else $error("tag byte not stored");

   property p_tag_inert;
      regWrEn && !updateActive &&
      (regAddr == `CGC_ADDR_TAG_LO || regAddr == `CGC_ADDR_TAG_HI)
      |=> $stable(phaseDetectorSense) && $stable(pumpCurrentSelect);
   endproperty
   a_tag_inert: assert property (p_tag_inert) else $error("tag write moved loop controls");

   property p_sense_xfer;
      updateActive |=> phaseDetectorSense ==
         $past(bankBus.bufSlots[`CGC_IDX_PUMP_CTRL][`CGC_SENSE_BIT]);
   endproperty
   a_sense_xfer: assert property (p_sense_xfer) else $error("sense not transferred");

   property p_pump_xfer;
      updateActive |=> pumpCurrentSelect ==
         $past(bankBus.bufSlots[`CGC_IDX_PUMP_CTRL][`CGC_PUMP_MSB:`CGC_PUMP_LSB]);
   endproperty
   a_pump_xfer: assert property (p_pump_xfer) else $error("pump select not transferred");

   property p_pump_hold;
      !updateActive |=> $stable(pumpCurrentSelect) && $stable(phaseDetectorSense);
   endproperty
   a_pump_hold: assert property (p_pump_hold) else $error("loop controls moved alone");

   property p_unmapped;
      regRdEn && !slotHit.hit && regAddr != `CGC_ADDR_VARIANT |=> regRdData == `CGC_RST_RDATA;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

   // every read strobe is answered one cycle later; without one the data holds
   property p_rd_strobe;
      regRdEn |=> regRdValid;
   endproperty
   a_rd_strobe: assert property (p_rd_strobe) else $error("read not answered");

   property p_rd_quiet;
      !regRdEn |=> !regRdValid && $stable(regRdData);
   endproperty
   a_rd_quiet: assert property (p_rd_quiet) else $error("read data moved without a read");

   // buffer readback returns the written copy
   property p_buf_read;
      regRdEn && slotHit.hit && rbBank == CGC_BANK_BUFFER
      |=> regRdData == $past(bankBus.bufSlots[slotHit.idx]);
   endproperty
   a_buf_read: assert property (p_buf_read) else $error("buffer readback wrong");

   // unused select bits never store, so software cannot read back junk there
   property p_sel_mask;
      regWrEn && regAddr == `CGC_ADDR_RB_SEL
      |=> (bankBus.bufSlots[`CGC_IDX_RB_SEL] & ~`CGC_RB_SEL_MASK) == 8'h00;
   endproperty
   a_sel_mask: assert property (p_sel_mask) else $error("select spare bits stored");

   // the active copy moves only on a transfer, and then takes the whole buffer
   property p_act_hold;
      !updateActive |=> $stable(bankBus.actSlots);
   endproperty
   a_act_hold: assert property (p_act_hold) else $error("active copy moved alone");

   property p_act_copy;
      updateActive |=> bankBus.actSlots == $past(bankBus.bufSlots);
   endproperty
   a_act_copy: assert property (p_act_copy) else $error("active copy incomplete");

   // the low tag byte stores like the high one
   property p_tag_lo_store;
      regWrEn && regAddr == `CGC_ADDR_TAG_LO ##1 !regWrEn ##1
      regRdEn && !regWrEn && regAddr == `CGC_ADDR_TAG_LO && rbBank == CGC_BANK_BUFFER
      |=> regRdData == $past(regWrData, 3);
   endproperty
   a_tag_lo_store: assert property (p_tag_lo_store) else $error("low tag not stored");

   // the identifier address never reaches a storage slot
   property p_id_no_slot;
      regAddr == `CGC_ADDR_VARIANT |-> !slotHit.hit;
   endproperty
   a_id_no_slot: assert property (p_id_no_slot) else $error("identifier decoded to a slot");

   c_active_read: cover property (regRdEn && slotHit.hit && rbBank == CGC_BANK_ACTIVE);
   c_write_update: cover property (regWrEn && regAddr == `CGC_ADDR_PUMP_CTRL ##1 updateActive);
   c_variant_write: cover property (regWrEn && regAddr == `CGC_ADDR_VARIANT);
   c_negative_sense: cover property ($rose(phaseDetectorSense));
   c_tag_roundtrip: cover property (regWrEn && regAddr == `CGC_ADDR_TAG_LO ##2 regRdEn);
endmodule
`default_nettype wire

// ===== sim/tb.sv
// Purpose: self-checking bench for the id and detector register block
// Assumes: one clock, synchronous active-low reset, one-cycle read latency
// Notes:   variant value is overridden with an arbitrary value of its own
`timescale 1ns/100ps
`default_nettype none
`include "cgc_map.svh"
module tb;
   import cgc_pkg::*;
   localparam cgc_byte_t VID = 8'h3C; // arbitrary value, not a real part code
   logic      sysClk;
   logic      resetN;
   cgc_addr_t regAddr;
   cgc_byte_t regWrData;
   logic      regWrEn;
   logic      regRdEn;
   logic      updateActive;
   cgc_byte_t regRdData;
   logic      regRdValid;
   logic      phaseDetectorSense;
   cgc_pump_t pumpCurrentSelect;
   int        n_fail;
   int        cmp_count;

   cgc_regs #(.VARIANT_ID(VID)) u_cgc_regs (
      .sys_clk            (sysClk),
      .reset_n            (resetN),
      .regAddr            (regAddr),
      .regWrData          (regWrData),
      .regWrEn            (regWrEn),
      .regRdEn            (regRdEn),
      .updateActive       (updateActive),
      .regRdData          (regRdData),
      .regRdValid         (regRdValid),
      .phaseDetectorSense (phaseDetectorSense),
      .pumpCurrentSelect  (pumpCurrentSelect)
   );

   // 100 ns period clock
   initial begin
      sysClk = 1'b0;
      forever #50 sysClk = ~sysClk;
   end

   // compare four-state values so an unknown never matches
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("compares %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // reset held for 12 edges; strobes stay low meanwhile
   task automatic do_reset();
      @(posedge sysClk);
      resetN <= 1'b0;
      repeat (12) @(posedge sysClk);
      resetN <= 1'b1;
   endtask

   task automatic wr(input cgc_addr_t a, input cgc_byte_t d);
      @(posedge sysClk);
      regAddr   <= a;
      regWrData <= d;
      regWrEn   <= 1'b1;
      @(posedge sysClk);
      regWrEn   <= 1'b0;
   endtask

   // answer is due exactly one cycle after the strobe is taken
   task automatic rd(input cgc_addr_t a, input cgc_byte_t exp);
      @(posedge sysClk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge sysClk);
      regRdEn <= 1'b0;
      #1;
      chk({7'h00, regRdValid}, 8'h01, "read valid");
      chk(regRdData, exp, "read data");
   endtask

   // transfer pulse, then outputs must show the new active copy
   task automatic upd(input logic s, input cgc_pump_t p);
      @(posedge sysClk);
      updateActive <= 1'b1;
      @(posedge sysClk);
      updateActive <= 1'b0;
      #1;
      chk({7'h00, phaseDetectorSense}, {7'h00, s}, "sense");
      chk({5'h00, pumpCurrentSelect}, {5'h00, p}, "pump");
   endtask

   // watchdog: the sequence needs well under 1000 cycles
   initial begin
      #(3000 * 100);
      n_fail++;
      give_verdict();
   end

   initial begin
      cgc_byte_t v;
      n_fail = 0;
      cmp_count = 0;
      resetN = 1'b0;
      regAddr = 10'h000;
      regWrData = 8'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      updateActive = 1'b0;
      do_reset();
      rd(`CGC_ADDR_VARIANT, VID);
      rd(`CGC_ADDR_RB_SEL, 8'h00);
      rd(`CGC_ADDR_TAG_LO, 8'h00);
      rd(`CGC_ADDR_TAG_HI, 8'h00);
      rd(`CGC_ADDR_PUMP_CTRL, 8'h7D);
      chk({7'h00, phaseDetectorSense}, 8'h00, "reset sense");
      chk({5'h00, pumpCurrentSelect}, 8'h07, "reset pump");
      wr(`CGC_ADDR_VARIANT, 8'hFF);
      rd(`CGC_ADDR_VARIANT, VID);
      rd(`CGC_ADDR_RB_SEL, 8'h00);
      // tag bytes store independently and touch no output
      wr(`CGC_ADDR_TAG_LO, 8'hA5);
      rd(`CGC_ADDR_TAG_LO, 8'hA5);
      wr(`CGC_ADDR_TAG_HI, 8'h3C);
      rd(`CGC_ADDR_TAG_HI, 8'h3C);
      rd(`CGC_ADDR_TAG_LO, 8'hA5);
      chk({7'h00, phaseDetectorSense}, 8'h00, "tag sense");
      chk({5'h00, pumpCurrentSelect}, 8'h07, "tag pump");
      // copying the tags into the active bank must leave the loop controls alone
      upd(1'b0, 3'h7);
      wr(10'h007, 8'h77);
      rd(10'h007, 8'h00);
      // buffer differs from active until the transfer
      wr(`CGC_ADDR_PUMP_CTRL, 8'h80);
      rd(`CGC_ADDR_PUMP_CTRL, 8'h80);
      wr(`CGC_ADDR_RB_SEL, 8'hFF);
      // the select register is banked too: its active copy still holds zero
      rd(`CGC_ADDR_RB_SEL, 8'h00);
      rd(`CGC_ADDR_PUMP_CTRL, 8'h7D);
      rd(`CGC_ADDR_VARIANT, VID);
      upd(1'b1, 3'h0);
      rd(`CGC_ADDR_RB_SEL, 8'h01);
      rd(`CGC_ADDR_PUMP_CTRL, 8'h80);
      // every pump code, with sense set to bit 0 of the code, read from the active copy
      for (int c = 0; c < 8; c++) begin
         v = {c[0], c[2:0], 4'hD};
         wr(`CGC_ADDR_PUMP_CTRL, v);
         upd(c[0], c[2:0]);
         rd(`CGC_ADDR_PUMP_CTRL, v);
      end
      wr(`CGC_ADDR_PUMP_CTRL, 8'h20);
      // leave the loop in positive sense, as software must with the internal oscillator
      upd(1'b0, 3'h2);
      wr(`CGC_ADDR_RB_SEL, 8'h00);
      rd(`CGC_ADDR_PUMP_CTRL, 8'h20);
      // a second reset clears the tag again
      do_reset();
      rd(`CGC_ADDR_TAG_LO, 8'h00);
      rd(`CGC_ADDR_TAG_HI, 8'h00);
      give_verdict();
   end
endmodule
`default_nettype wire
